// ### fbas_pkg.sv
package fbas_pkg;

	// Register bus geometry
	localparam int          AXI_AW     = 8;
	localparam logic [1:0]  AXI_OKAY   = 2'h0;
	localparam logic [1:0]  AXI_SLVERR = 2'h2;

	// Register byte offsets
	localparam logic [7:0]  REG_STATUS = 8'h00;
	localparam logic [7:0]  REG_MASK   = 8'h04;
	localparam logic [7:0]  REG_CODE   = 8'h08;
	localparam logic [7:0]  REG_CTRL   = 8'h0C;
	localparam logic [7:0]  REG_THRESH = 8'h10;
	localparam logic [7:0]  REG_PDWDT  = 8'h14;
	localparam logic [7:0]  REG_SYWDT  = 8'h18;

	// Field positions
	localparam int          CTRL_ACK_BIT = 0;
	localparam int          CODE_ERR_BIT = 16;

	// Event bits of the status and mask registers
	localparam int          EV_N       = 14;
	localparam int          EV_ILLEGAL = 0;
	localparam int          EV_UNKNOWN = 1;
	localparam int          EV_BOOT    = 2;
	localparam int          EV_SII_A   = 3;
	localparam int          EV_MBX     = 4;
	localparam int          EV_COMM    = 5;
	localparam int          EV_SYNC    = 6;
	localparam int          EV_PDWDT   = 7;
	localparam int          EV_RXPDO   = 8;
	localparam int          EV_TXPDO   = 9;
	localparam int          EV_WDTCFG  = 10;
	localparam int          EV_SII_B   = 11;
	localparam int          EV_NODE    = 12;
	localparam int          EV_CYCLE   = 13;

	// Status code reported for each event bit, indexed as above
	localparam logic [15:0] EV_CODE [EV_N] = '{
		16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0016, 16'h001A, 16'h001A,
		16'h001B, 16'h001D, 16'h001E, 16'h001F, 16'h0020, 16'h0021, 16'h0035};

	// Link state encodings
	localparam logic [3:0]  ALS_INIT   = 4'h1;
	localparam logic [3:0]  ALS_PREOP  = 4'h2;
	localparam logic [3:0]  ALS_BOOT   = 4'h3;
	localparam logic [3:0]  ALS_SAFEOP = 4'h4;
	localparam logic [3:0]  ALS_OP     = 4'h8;

	// Supported synchronous cycle period, microseconds
	localparam logic [15:0] CYC_MIN_US = 16'h00FA;
	localparam logic [15:0] CYC_MAX_US = 16'h2710;

	// Timing
	localparam int          CLK_NS        = 50;
	localparam int          PD_WDT_US     = 100;
	localparam int          SY_WDT_US     = 200;
	localparam int          PD_WDT_CYC    = (PD_WDT_US * 1000) / CLK_NS;
	localparam int          SY_WDT_CYC    = (SY_WDT_US * 1000) / CLK_NS;
	localparam logic [7:0]  THRESH_RST    = 8'h02;
	localparam logic [8:0]  ERRCNT_MAX    = 9'h1FF;
	localparam logic [15:0] WD_STEP       = 16'h0001;
	localparam logic [8:0]  EC_STEP       = 9'h001;

	typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_TRIP} fbas_wd_e;

	// Link-side inputs
	typedef struct packed {
		logic        st_req_valid;
		logic [3:0]  st_req;
		logic [3:0]  st_cur;
		logic        sii_valid;
		logic        sii_match;
		logic        sii_late;
		logic        mbx_valid;
		logic        mbx_ok;
		logic        rxpdo_valid;
		logic        rxpdo_ok;
		logic        txpdo_valid;
		logic        txpdo_ok;
		logic        wdtcfg_valid;
		logic        wdtcfg_ok;
		logic        cyc_valid;
		logic [15:0] cyc_period;
		logic        rx_err;
		logic        rx_ok;
		logic        sync0;
		logic        pd_frame;
		logic        pd_active;
		logic        link_up;
		logic [7:0]  node_addr;
		logic        al_ack;
	} fbas_link_s;

	// Status code toward the master
	typedef struct packed {
		logic        err;
		logic [15:0] code;
	} fbas_al_s;

	typedef struct packed {
		fbas_wd_e    st;
		logic [15:0] cnt;
		logic        expire;
	} fbas_wd_s;

	typedef struct packed {
		logic [8:0]  cnt;
		logic        over;
	} fbas_ec_s;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic [EV_N-1:0]   status;
		logic [EV_N-1:0]   mask;
		fbas_al_s          al;
		logic [7:0]        thresh;
		logic [15:0]       pd_to;
		logic [15:0]       sy_to;
		logic [7:0]        node_lat;
		logic              node_ok;
		logic              irq;
	} fbas_top_s;

endpackage : fbas_pkg

// ### fbas_wdog.sv
`timescale 1ns/1ps
module fbas_wdog import fbas_pkg::*; (
	input  wire logic        aclk,    // Clock
	input  wire logic        aresetn, // Synchronous reset, active low
	input  wire logic        en,      // Supervision active
	input  wire logic        kick,    // Expected event seen
	input  wire logic [15:0] limit,   // Timeout in clock cycles, zero keeps an idle watchdog from arming but trips an armed one at once
	output logic             expire   // One-cycle pulse on timeout
);

	fbas_wd_s q;
	fbas_wd_s n;

	always_comb begin
		n = q;
		n.expire = 1'b0;
		case (q.st)
			WD_IDLE: begin
				if (en && limit != '0) begin
					n.st = WD_ARMED;
					n.cnt = '0;
				end
			end
			WD_ARMED: begin
				if (kick) begin
					n.cnt = '0;
				end else if (q.cnt + WD_STEP >= limit) begin
					n.st = WD_TRIP;
					n.expire = 1'b1;
				end else begin
					n.cnt = q.cnt + WD_STEP;
				end
			end
			WD_TRIP: begin
				if (kick) begin
					n.st = WD_ARMED;
					n.cnt = '0;
				end
			end
			default: n.st = WD_IDLE;
		endcase
		if (!en) begin
			n.st = WD_IDLE;
			n.expire = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign expire = q.expire;

	sequence kick_s;
		en && kick;
	endsequence

	sequence last_s;
		q.st == WD_ARMED && en && !kick && q.cnt + WD_STEP >= limit;
	endsequence

	wd_kick_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		kick_s |=> !expire)
		else $error("watchdog expired right after a kick");

	wd_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		last_s |=> expire ##1 !expire)
		else $error("watchdog missed its timeout pulse");

endmodule : fbas_wdog

// ### fbas_errcnt.sv
`timescale 1ns/1ps
module fbas_errcnt import fbas_pkg::*; (
	input  wire logic       aclk,    // Clock
	input  wire logic       aresetn, // Synchronous reset, active low
	input  wire logic       rx_err,  // Frame received with error
	input  wire logic       rx_ok,   // Frame received intact
	input  wire logic [7:0] thresh,  // Allowed consecutive errors
	output logic            over     // One-cycle pulse when count passes thresh
);

	fbas_ec_s q;
	fbas_ec_s n;

	always_comb begin
		n = q;
		n.over = 1'b0;
		if (rx_ok) begin
			n.cnt = '0;
		end else if (rx_err && q.cnt != ERRCNT_MAX) begin
			n.cnt = q.cnt + EC_STEP;
			n.over = (n.cnt == {1'b0, thresh} + EC_STEP); // RL8
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign over = q.over;

	ec_exceed_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		(rx_err && !rx_ok && q.cnt == {1'b0, thresh}) |=> over)
		else $error("error count passed threshold without report");

	ec_good_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		rx_ok |=> q.cnt == '0 && !over)
		else $error("good frame did not restart the error count");

endmodule : fbas_errcnt

// ### fbas_top.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Operation
// (RL1) Disallowed transition request reports 0011 hex
// (RL2) Unknown target state reports 0012 hex
// (RL3) Refuse bootstrap request, report 0013 hex
// (RL4) Master never requests bootstrap state
// (RL5) Master sends only valid known requests
// (RL6) Identity mismatch reports 0014 or 0020 hex
// (RL7) Bad mailbox channel setting reports 0016 hex
// (RL8) Consecutive receive errors over threshold: 001A
// (RL9) Sync0 lost during process data: 001A
// (RL10) Process data watchdog expiry reports 001B
// (RL11) Bad receive sync manager setting: 001D
// (RL12) Bad transmit sync manager setting: 001E
// (RL13) Bad watchdog setting reports 001F hex
// (RL14) Node address changed without power cycle: 0021
// (RL15) Every fault shown as its status code; of faults arriving in one cycle only the lowest event bit's code is shown
// (RL16) Unsupported cycle period reports 0035 hex
// (RL17) Hold code and flag until acknowledged
module fbas_top import fbas_pkg::*; #(
	parameter int SY_WDT_CYCLES = SY_WDT_CYC    // Sync0 loss timeout, cycles
) (
	input  wire logic              aclk,          // Clock, 20 MHz
	input  wire logic              aresetn,       // Synchronous reset, active low
	input  wire fbas_link_s        link,          // Link-side events and settings
	output fbas_al_s               al,            // Status code and error flag
	output logic                   irq,           // Level interrupt
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,  // Write address
	input  wire logic              s_axi_awvalid, // Write address valid
	output logic                   s_axi_awready, // Write address ready
	input  wire logic [31:0]       s_axi_wdata,   // Write data
	input  wire logic [3:0]        s_axi_wstrb,   // Write byte enables
	input  wire logic              s_axi_wvalid,  // Write data valid
	output logic                   s_axi_wready,  // Write data ready
	output logic [1:0]             s_axi_bresp,   // Write response
	output logic                   s_axi_bvalid,  // Write response valid
	input  wire logic              s_axi_bready,  // Write response ready
	input  wire logic [AXI_AW-1:0] s_axi_araddr,  // Read address
	input  wire logic              s_axi_arvalid, // Read address valid
	output logic                   s_axi_arready, // Read address ready
	output logic [31:0]            s_axi_rdata,   // Read data
	output logic [1:0]             s_axi_rresp,   // Read response
	output logic                   s_axi_rvalid,  // Read data valid
	input  wire logic              s_axi_rready   // Read data ready
);

	fbas_top_s       q;
	fbas_top_s       n;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] w1c;
	logic            clr;
	logic            cnt_over;
	logic            sync_exp;
	logic            pd_exp;

	function automatic logic st_known(input logic [3:0] s);
		return s == ALS_INIT || s == ALS_PREOP || s == ALS_BOOT ||
			s == ALS_SAFEOP || s == ALS_OP;
	endfunction : st_known

	// Stepping down or staying is allowed except from bootstrap or an unknown state, stepping up only one level
	function automatic logic st_allowed(input logic [3:0] cur, input logic [3:0] req);
		if (!st_known(cur) || cur == ALS_BOOT) begin
			return 1'b0;
		end
		return req <= cur ||
			(cur == ALS_INIT && req == ALS_PREOP) ||
			(cur == ALS_PREOP && req == ALS_SAFEOP) ||
			(cur == ALS_SAFEOP && req == ALS_OP);
	endfunction : st_allowed

	// Lowest event bit wins when several fire together
	function automatic logic [3:0] ev_first(input logic [EV_N-1:0] e);
		logic [3:0] idx;
		idx = '0;
		for (int i = EV_N - 1; i >= 0; i--) begin
			if (e[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : ev_first

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic cyc_bad(input logic [15:0] p);
		return p < CYC_MIN_US || p > CYC_MAX_US;
	endfunction : cyc_bad

	fbas_errcnt u_errcnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rx_err  (link.rx_err),
		.rx_ok   (link.rx_ok),
		.thresh  (q.thresh),
		.over    (cnt_over)
	);

	fbas_wdog u_sync_wdog (
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (link.pd_active),
		.kick    (link.sync0),
		.limit   (q.sy_to),
		.expire  (sync_exp)
	);

	fbas_wdog u_pd_wdog (
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (link.pd_active),
		.kick    (link.pd_frame),
		.limit   (q.pd_to),
		.expire  (pd_exp)
	);

	always_comb begin
		logic [31:0] wv;
		wv = '0;
		n = q;
		ev = '0;
		w1c = '0;
		clr = 1'b0;

		// Write channel: address and data taken in either order
		if (s_axi_bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_awvalid && q.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (q.aw_got && q.w_got && !q.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = AXI_OKAY;
			case (q.awaddr)
				REG_STATUS: begin
					wv = wmerge('0, q.wdata, q.wstrb);
					w1c = wv[EV_N-1:0];
				end
				REG_MASK: begin
					wv = wmerge(32'(q.mask), q.wdata, q.wstrb);
					n.mask = wv[EV_N-1:0];
				end
				REG_CTRL: begin
					wv = wmerge('0, q.wdata, q.wstrb);
					clr = wv[CTRL_ACK_BIT];
				end
				REG_THRESH: begin
					wv = wmerge(32'(q.thresh), q.wdata, q.wstrb);
					n.thresh = wv[7:0];
				end
				REG_PDWDT: begin
					wv = wmerge(32'(q.pd_to), q.wdata, q.wstrb);
					n.pd_to = wv[15:0];
				end
				REG_SYWDT: begin
					wv = wmerge(32'(q.sy_to), q.wdata, q.wstrb);
					n.sy_to = wv[15:0];
				end
				REG_CODE: n.bresp = AXI_OKAY;
				default: n.bresp = AXI_SLVERR;
			endcase
		end

		// Read channel
		if (s_axi_rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			n.rvalid = 1'b1;
			n.rresp = AXI_OKAY;
			case (s_axi_araddr)
				REG_STATUS: n.rdata = 32'(q.status);
				REG_MASK:   n.rdata = 32'(q.mask);
				REG_CODE:   n.rdata = 32'(q.al);
				REG_CTRL:   n.rdata = '0;
				REG_THRESH: n.rdata = 32'(q.thresh);
				REG_PDWDT:  n.rdata = 32'(q.pd_to);
				REG_SYWDT:  n.rdata = 32'(q.sy_to);
				default: begin
					n.rdata = '0;
					n.rresp = AXI_SLVERR;
				end
			endcase
		end

		// State transition requests, bootstrap checked first
		if (link.st_req_valid) begin
			if (link.st_req == ALS_BOOT) begin
				ev[EV_BOOT] = 1'b1; // RL3
			end else if (!st_known(link.st_req)) begin
				ev[EV_UNKNOWN] = 1'b1; // RL2
			end else if (!st_allowed(link.st_cur, link.st_req)) begin
				ev[EV_ILLEGAL] = 1'b1; // RL1
			end
		end

		ev[EV_SII_A] = link.sii_valid && !link.sii_match && !link.sii_late; // RL6
		ev[EV_SII_B] = link.sii_valid && !link.sii_match && link.sii_late; // RL6
		ev[EV_MBX] = link.mbx_valid && !link.mbx_ok; // RL7
		ev[EV_COMM] = cnt_over; // RL8
		ev[EV_SYNC] = sync_exp; // RL9
		ev[EV_PDWDT] = pd_exp; // RL10
		ev[EV_RXPDO] = link.rxpdo_valid && !link.rxpdo_ok; // RL11
		ev[EV_TXPDO] = link.txpdo_valid && !link.txpdo_ok; // RL12
		ev[EV_WDTCFG] = link.wdtcfg_valid && !link.wdtcfg_ok; // RL13
		ev[EV_CYCLE] = link.cyc_valid && cyc_bad(link.cyc_period); // RL16

		// Node address caught once after reset release
		if (!q.node_ok) begin
			n.node_lat = link.node_addr; // RL14
			n.node_ok = 1'b1;
		end
		ev[EV_NODE] = link.link_up && q.node_ok && link.node_addr != q.node_lat; // RL14

		// A new fault wins over an acknowledge in the same cycle
		clr = clr | link.al_ack;
		if (|ev) begin
			n.al.code = EV_CODE[ev_first(ev)]; // RL15
			n.al.err = 1'b1; // RL17
		end else if (clr) begin
			n.al = '0; // RL17
		end
		n.status = (q.status & ~w1c) | ev;
		n.irq = |(n.status & n.mask);

		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.thresh <= THRESH_RST;
			q.pd_to <= 16'(PD_WDT_CYC);
			q.sy_to <= 16'(SY_WDT_CYCLES);
		end else begin
			q <= n;
		end
	end

	assign al = q.al;
	assign irq = q.irq;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence boot_req_s;
		link.st_req_valid && link.st_req == ALS_BOOT;
	endsequence

	sequence unknown_req_s;
		link.st_req_valid && !st_known(link.st_req);
	endsequence

	illegal_req_a: assert property ( // RL1
		(link.st_req_valid && st_known(link.st_req) && link.st_req != ALS_BOOT &&
		!st_allowed(link.st_cur, link.st_req)) |=> q.status[EV_ILLEGAL] && q.al.err)
		else $error("disallowed transition not reported");

	unknown_req_a: assert property ( // RL2
		unknown_req_s |=> q.status[EV_UNKNOWN])
		else $error("unknown target state not reported");

	boot_refuse_a: assert property ( // RL3
		boot_req_s |=> q.status[EV_BOOT] && q.al.code == EV_CODE[EV_BOOT] &&
		!$rose(q.status[EV_ILLEGAL]))
		else $error("bootstrap request not refused");

	sii_mismatch_a: assert property ( // RL6
		(link.sii_valid && !link.sii_match) |=>
		q.status[$past(link.sii_late) ? EV_SII_B : EV_SII_A])
		else $error("identity mismatch not reported");

	sync_loss_a: assert property ( // RL9
		sync_exp |=> q.status[EV_SYNC] && q.al.err)
		else $error("sync loss not reported");

	code_value_a: assert property ( // RL15
		(|ev) |=> q.al.code == EV_CODE[$past(ev_first(ev))] && q.al.err)
		else $error("status code does not match the fault");

	code_hold_a: assert property ( // RL17
		(q.al.err && !(|ev) && !clr) |=> $stable(q.al) ##1 q.al.err || $past(clr) || $past(|ev))
		else $error("status code changed without acknowledge");

	node_change_a: assert property ( // RL14
		(link.link_up && q.node_ok && link.node_addr != q.node_lat) |=>
		q.status[EV_NODE] && $stable(q.node_lat))
		else $error("node address change not reported");

	cycle_bad_a: assert property ( // RL16
		(link.cyc_valid && cyc_bad(link.cyc_period)) |=> q.al.err && q.status[EV_CYCLE])
		else $error("unsupported cycle period not reported");

	irq_level_a: assert property (
		irq == |(q.status & q.mask))
		else $error("interrupt does not follow masked status");

endmodule : fbas_top

// ### fbas_master_model.sv
`timescale 1ns/1ps
module fbas_master_model import fbas_pkg::*; (
	input  wire logic aclk, // Clock
	output fbas_link_s link  // Link events toward the drive
);
	fbas_link_s lv;
	logic       rogue = 1'b0;
	logic       feed_pd = 1'b0;
	logic       feed_sy = 1'b0;
	logic [1:0] ph_q = 2'h0;

	initial begin
		lv = '0;
		lv.st_cur = ALS_INIT;
		lv.node_addr = 8'h05;
	end

	always @(posedge aclk) ph_q <= ph_q + 2'h1;

	// Frames and sync0 come every fourth cycle while feeding is on
	always_comb begin
		link = lv;
		link.pd_frame = lv.pd_frame | (feed_pd & (ph_q == 2'h0));
		link.sync0 = lv.sync0 | (feed_sy & (ph_q == 2'h2));
	end

	// Idle copy taken after the edge, and one edge left at the end, so that
	// a pulse issued right after another never inherits its fields
	task automatic pulse(input fbas_link_s v);
		fbas_link_s old;
		@(posedge aclk);
		old = lv;
		lv <= v;
		@(posedge aclk);
		lv <= old;
		@(posedge aclk);
	endtask : pulse

	task automatic run(input logic act, input logic fp, input logic fs);
		@(posedge aclk);
		lv.pd_active <= act;
		feed_pd <= fp;
		feed_sy <= fs;
	endtask : run

	// Only a deliberately misbehaving master asks for boot or unknown states
	task automatic request(input logic [3:0] cur, input logic [3:0] tgt);
		fbas_link_s v;
		v = lv;
		v.st_req_valid = 1'b1;
		v.st_cur = cur;
		v.st_req = tgt;
		if (!rogue && tgt == ALS_BOOT) return;
		if (!rogue && !(tgt inside {ALS_INIT, ALS_PREOP, ALS_SAFEOP, ALS_OP})) return;
		pulse(v);
	endtask : request

	task automatic cfg(input int sel, input logic ok, input logic [15:0] arg);
		fbas_link_s v;
		v = lv;
		case (sel)
			0: v.mbx_valid = 1'b1;
			1: v.rxpdo_valid = 1'b1;
			2: v.txpdo_valid = 1'b1;
			3: v.wdtcfg_valid = 1'b1;
			4: v.sii_valid = 1'b1;
			5: v.cyc_valid = 1'b1;
			6: v.rx_err = 1'b1;
			7: v.rx_ok = 1'b1;
			8: v.link_up = 1'b1;
			9: v.al_ack = 1'b1;
			default: begin
				v.mbx_valid = 1'b1;
				v.txpdo_valid = 1'b1;
			end
		endcase
		v.mbx_ok = ok;
		v.rxpdo_ok = ok;
		v.txpdo_ok = ok;
		v.wdtcfg_ok = ok;
		v.sii_match = ok;
		v.sii_late = arg[0];
		v.cyc_period = arg;
		if (sel == 8) v.node_addr = arg[7:0];
		pulse(v);
	endtask : cfg
endmodule : fbas_master_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top import fbas_pkg::*; ;
	localparam int SYC = 20;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	fbas_link_s        link;
	fbas_al_s          al;
	logic              irq;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0]       wdata = '0, rdata;
	logic [3:0]        wstrb = '0;
	logic [1:0]        bresp, rresp;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	int                n_mismatch = 0;
	int                compares = 0;

	always #25 aclk = ~aclk;

	fbas_master_model m (.aclk(aclk), .link(link));
	fbas_top #(.SY_WDT_CYCLES(SYC)) uut (
		.aclk(aclk), .aresetn(aresetn), .link(link), .al(al), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk_resp

	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got && n < 200) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				got = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
		if (!got) chk("write answer", 32'h1, 32'h0);
	endtask : wr

	task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		d = '0;
		r = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got && n < 200) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				got = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
		if (!got) chk("read answer", 32'h1, 32'h0);
	endtask : rd

	task automatic wok(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk_resp("write resp", AXI_OKAY, r);
	endtask : wok

	task automatic rchk(input string nm, input logic [AXI_AW-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk_resp("read resp", AXI_OKAY, r);
		chk(nm, e, d);
	endtask : rchk

	// A zero code means nothing may be reported
	task automatic check_ev(input int b, input logic [15:0] code);
		logic [31:0] e;
		e = (code == 16'h0) ? 32'h0 : (32'h1 << b);
		repeat (4) @(posedge aclk);
		chk("al", {15'h0, |e, code}, {15'h0, al});
		rchk("code reg", REG_CODE, {15'h0, |e, code});
		rchk("status", REG_STATUS, e);
		wok(REG_STATUS, e);
		wok(REG_CTRL, 32'h1);
		rchk("status clr", REG_STATUS, 32'h0);
		chk("al clr", 32'h0, {15'h0, al});
	endtask : check_ev

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		chk("al", 32'h0, {15'h0, al});
		chk("irq", 32'h0, {31'h0, irq});
		rchk("status", REG_STATUS, 32'h0);
		rchk("mask", REG_MASK, 32'h0);
		rchk("thresh", REG_THRESH, 32'h2);
		rchk("pdwdt", REG_PDWDT, 32'h7D0);
		rchk("sywdt", REG_SYWDT, SYC);
		rchk("ctrl", REG_CTRL, 32'h0);
		rd(8'h40, d, r);
		chk_resp("unmapped rresp", AXI_SLVERR, r);
		chk("unmapped data", 32'h0, d);
		wr(8'h40, 32'hFFFFFFFF, r);
		chk_resp("unmapped bresp", AXI_SLVERR, r);
		wok(REG_CODE, 32'h1FFFF);
		rchk("code ro", REG_CODE, 32'h0);
		$display("test reset and registers done");
	endtask : t_reset

	task automatic t_state;
		logic [3:0]  cu [6] = '{ALS_PREOP, ALS_INIT, ALS_INIT, ALS_SAFEOP, ALS_OP, ALS_BOOT};
		logic [3:0]  tg [6] = '{ALS_BOOT, 4'h5, ALS_OP, ALS_OP, ALS_INIT, ALS_PREOP};
		int          bt [6] = '{EV_BOOT, EV_UNKNOWN, EV_ILLEGAL, 0, 0, EV_ILLEGAL};
		logic [15:0] cd [6] = '{16'h0013, 16'h0012, 16'h0011, 16'h0, 16'h0, 16'h0011};
		m.rogue = 1'b1;
		for (int i = 0; i < 6; i++) begin
			m.request(cu[i], tg[i]);
			check_ev(bt[i], cd[i]);
		end
		m.rogue = 1'b0;
		m.request(ALS_INIT, ALS_BOOT);
		check_ev(0, 16'h0);
		$display("test state requests done");
	endtask : t_state

	task automatic t_cfg;
		int          sl [12] = '{0, 0, 1, 2, 3, 4, 4, 4, 5, 5, 5, 5};
		logic        ok [12] = '{0, 1, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
		logic [15:0] ag [12] = '{0, 0, 0, 0, 0, 0, 1, 0, 16'h0064, 16'h00FA, 16'h2710, 16'h2711};
		int          bt [12] = '{EV_MBX, 0, EV_RXPDO, EV_TXPDO, EV_WDTCFG, EV_SII_A,
			EV_SII_B, 0, EV_CYCLE, 0, 0, EV_CYCLE};
		logic [15:0] cd [12] = '{16'h0016, 16'h0, 16'h001D, 16'h001E, 16'h001F, 16'h0014,
			16'h0020, 16'h0, 16'h0035, 16'h0, 16'h0, 16'h0035};
		for (int i = 0; i < 12; i++) begin
			m.cfg(sl[i], ok[i], ag[i]);
			check_ev(bt[i], cd[i]);
		end
		$display("test settings done");
	endtask : t_cfg

	task automatic t_comm;
		repeat (2) m.cfg(6, 1'b0, 16'h0);
		m.cfg(7, 1'b0, 16'h0);
		repeat (2) m.cfg(6, 1'b0, 16'h0);
		check_ev(0, 16'h0);
		m.cfg(6, 1'b0, 16'h0);
		check_ev(EV_COMM, 16'h001A);
		wok(REG_THRESH, 32'h0);
		m.cfg(7, 1'b0, 16'h0);
		m.cfg(6, 1'b0, 16'h0);
		check_ev(EV_COMM, 16'h001A);
		wok(REG_THRESH, 32'h2);
		m.cfg(7, 1'b0, 16'h0);
		$display("test receive errors done");
	endtask : t_comm

	task automatic t_wdog;
		wok(REG_PDWDT, 32'hA);
		m.run(1'b1, 1'b1, 1'b1);
		repeat (60) @(posedge aclk);
		check_ev(0, 16'h0);
		m.run(1'b1, 1'b0, 1'b1);
		repeat (30) @(posedge aclk);
		check_ev(EV_PDWDT, 16'h001B);
		m.run(1'b0, 1'b0, 1'b0);
		m.run(1'b1, 1'b1, 1'b0);
		repeat (60) @(posedge aclk);
		check_ev(EV_SYNC, 16'h001A);
		m.run(1'b0, 1'b0, 1'b0);
		$display("test watchdogs done");
	endtask : t_wdog

	task automatic t_irq;
		wok(REG_MASK, 32'h1 << EV_TXPDO);
		rchk("mask", REG_MASK, 32'h1 << EV_TXPDO);
		m.cfg(2, 1'b0, 16'h0);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		wok(REG_MASK, 32'h0);
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wok(REG_MASK, 32'h1 << EV_TXPDO);
		m.cfg(10, 1'b0, 16'h0);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		chk("al lowest", {15'h0, 1'b1, 16'h0016}, {15'h0, al});
		rchk("status", REG_STATUS, (32'h1 << EV_MBX) | (32'h1 << EV_TXPDO));
		wok(REG_STATUS, (32'h1 << EV_MBX) | (32'h1 << EV_TXPDO));
		repeat (2) @(posedge aclk);
		chk("irq clr", 32'h0, {31'h0, irq});
		chk("al held", {15'h0, 1'b1, 16'h0016}, {15'h0, al});
		m.cfg(9, 1'b0, 16'h0);
		repeat (3) @(posedge aclk);
		chk("al ack", 32'h0, {15'h0, al});
		wok(REG_MASK, 32'h0);
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_node;
		m.cfg(8, 1'b0, 16'h0005);
		check_ev(0, 16'h0);
		m.cfg(8, 1'b0, 16'h0006);
		check_ev(EV_NODE, 16'h0021);
		$display("test node address done");
	endtask : t_node

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_state;
		t_cfg;
		t_comm;
		t_wdog;
		t_irq;
		t_node;
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		print_verdict;
	end
endmodule : tb_top
